// File: design/sspb_pkg.sv
// constants, register map and types for the synchronous serial port
package sspb_pkg;

  // register port geometry
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 3;

  // register word offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_TBUF = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_RBUF = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_BAUD = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_STAT = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_MASK = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_PORT = 3'h6;

  // control register fields
  localparam int unsigned CTRL_EN     = 0;
  localparam int unsigned CTRL_MASTER = 1;
  localparam int unsigned CTRL_MSB    = 2;
  localparam int unsigned CTRL_OD     = 3;
  localparam int unsigned CTRL_WID_LO = 4;
  localparam int unsigned CTRL_WID_HI = 7;

  // port register fields: latches low, directions from DIR_LO
  localparam int unsigned PIN_CLK  = 0;
  localparam int unsigned PIN_MOSI = 1;
  localparam int unsigned PIN_MISO = 2;
  localparam int unsigned DIR_LO   = 4;

  // status and mask fields
  localparam int unsigned STAT_TX = 0;
  localparam int unsigned STAT_RX = 1;

  // values after reset; minimum frame width used for a zero width field
  localparam logic [DATA_W-1:0] CTRL_RST = 16'h0070;
  localparam logic [DATA_W-1:0] BAUD_RST = 16'h0001;
  localparam logic [DATA_W-1:0] PORT_RST = 16'h0007;
  localparam logic [1:0]        STAT_RST = 2'h0;
  localparam logic [4:0]        MIN_WIDTH = 5'h02;

  // frame sequencer states
  typedef enum logic {ST_IDLE, ST_RUN} sspb_state_t;

endpackage

// File: design/sspb_baud.sv
// dedicated down-counting baud timer with reload, run at half the core clock
module sspb_baud (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  // control
  input  wire logic                       run,
  input  wire logic [sspb_pkg::DATA_W-1:0] reload,
  // timer state and ticks
  output logic      [sspb_pkg::DATA_W-1:0] count,
  output logic                            tick,
  output logic                            mid
);
  import sspb_pkg::*;

  logic                pre_q;
  logic [DATA_W-1:0]   cnt_q;
  logic                tick_q;
  logic                mid_q;
  logic [DATA_W-1:0]   half;
  logic                under;

  // half-period point, underflow condition
  assign half  = DATA_W'((17'(reload) + 17'h00001) >> 1);
  assign under = pre_q & (cnt_q == 16'h0000);

  // prescaler by two and down counter; stopped timer sits at reload
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q  <= 1'b0;
      cnt_q  <= BAUD_RST;
      tick_q <= 1'b0;
      mid_q  <= 1'b0;
    end else if (!run) begin
      pre_q  <= 1'b0;
      cnt_q  <= reload;
      tick_q <= 1'b0;
      mid_q  <= 1'b0;
    end else begin
      pre_q  <= ~pre_q;
      tick_q <= under;
      mid_q  <= pre_q & (cnt_q == half);
      if (pre_q) begin
        cnt_q <= under ? reload : cnt_q - 16'h0001;
      end
    end
  end

  assign count = cnt_q;
  assign tick  = tick_q;
  assign mid   = mid_q;

  property p_reload_on_underflow;
    @(posedge core_clk) disable iff (!rst_n)
    run && under |=> tick_q && cnt_q == $past(reload);
  endproperty
  a_reload_on_underflow: assert property (p_reload_on_underflow)
    else $error("baud timer did not reload and tick on underflow");

  property p_count_down;
    @(posedge core_clk) disable iff (!rst_n)
    run && pre_q && cnt_q != 16'h0000 |=> cnt_q == $past(cnt_q) - 16'h0001;
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("baud timer did not count down");

  property p_stopped;
    @(posedge core_clk) disable iff (!rst_n)
    !run |=> !tick_q && !mid_q && cnt_q == $past(reload);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("baud timer ran while channel disabled");

endmodule // sspb_baud

// File: design/sspb_top.sv
// synchronous serial port: shifter, pin control, baud timer and registers
module sspb_top (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  // register port
  input  wire logic [sspb_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [sspb_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [sspb_pkg::DATA_W-1:0] reg_rdata,
  // interrupt
  output logic                             irq,
  // clock pin
  input  wire logic                        clk_pin_in,
  output logic                             clk_pin_out,
  output logic                             clk_pin_oe,
  // master-out slave-in pin
  input  wire logic                        mosi_pin_in,
  output logic                             mosi_pin_out,
  output logic                             mosi_pin_oe,
  // master-in slave-out pin
  input  wire logic                        miso_pin_in,
  output logic                             miso_pin_out,
  output logic                             miso_pin_oe
);
  import sspb_pkg::*;

  // picks the bit that goes out first or next
  function automatic logic pick_bit(input logic [DATA_W-1:0] v,
                                    input logic [4:0]        w,
                                    input logic              msb);
    pick_bit = msb ? v[4'(w - 5'h01)] : v[0];
  endfunction

  logic [DATA_W-1:0] ctrl_q, tb_q, rb_q, baud_q, port_q;
  logic [1:0]        stat_q, mask_q, stat_d, stat_set;
  logic              tb_full_q, irq_q;
  logic [DATA_W-1:0] rdata_q, rd_mux;
  logic [2:0]        s1_q, s2_q, s3_q, filt_q, pin_in;
  logic              sclk_prev_q, sclk_q, dout_q;
  sspb_state_t       state_q;
  logic [DATA_W-1:0] shift_q, shifted, lsb_sh, wmsk;
  logic [4:0]        cnt_q, width;
  logic [DATA_W-1:0] baud_count;
  logic              baud_tick, baud_mid;
  logic [2:0]        pout_q, poe_q, pout_d, poe_d;

  // control decode
  logic en, master, msb, od, din, s_rise, s_fall;
  logic sample_edge, shift_edge, frame_done, load_start, load_cont, load;
  logic alt_clk, alt_mosi, alt_miso;
  logic wr_ctrl, wr_tb, wr_baud, wr_stat, wr_mask, wr_port;
  assign en      = ctrl_q[CTRL_EN];
  assign master  = ctrl_q[CTRL_MASTER];
  assign msb     = ctrl_q[CTRL_MSB];
  assign od      = ctrl_q[CTRL_OD];
  assign width   = (ctrl_q[CTRL_WID_HI:CTRL_WID_LO] == 4'h0) ? MIN_WIDTH
                 : {1'b0, ctrl_q[CTRL_WID_HI:CTRL_WID_LO]} + 5'h01;
  assign wr_ctrl = reg_wr & (reg_addr == OFS_CTRL);
  assign wr_tb   = reg_wr & (reg_addr == OFS_TBUF);
  assign wr_baud = reg_wr & (reg_addr == OFS_BAUD);
  assign wr_stat = reg_wr & (reg_addr == OFS_STAT);
  assign wr_mask = reg_wr & (reg_addr == OFS_MASK);
  assign wr_port = reg_wr & (reg_addr == OFS_PORT);

  // pin input synchronisers: a change counts once stages two and three agree
  assign pin_in = {miso_pin_in, mosi_pin_in, clk_pin_in};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q   <= 3'h7;
      s2_q   <= 3'h7;
      s3_q   <= 3'h7;
      filt_q <= 3'h7;
    end else begin
      s1_q   <= pin_in;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
    end
  end

  // edges of the received shift clock in slave mode
  assign s_rise = filt_q[PIN_CLK] & ~sclk_prev_q;
  assign s_fall = ~filt_q[PIN_CLK] & sclk_prev_q;

  // role routing: sample/shift edges and data input per mode
  assign sample_edge = en & (master ? (baud_mid & (state_q == ST_RUN)) : s_rise);
  assign shift_edge  = en & (master ? baud_tick : s_fall);
  assign din         = master ? filt_q[PIN_MISO] : filt_q[PIN_MOSI];
  assign frame_done  = sample_edge & (cnt_q == width - 5'h01);

  // buffer to shifter transfers: first word, and back-to-back continuation
  assign load_start = en & tb_full_q & (state_q == ST_IDLE) & (master ? baud_tick : 1'b1);
  assign load_cont  = frame_done & tb_full_q;
  assign load       = load_start | load_cont;

  // next shifter contents, right aligned for either bit order
  assign wmsk    = 16'h0001 << (width - 5'h01);
  assign lsb_sh  = {1'b0, shift_q[DATA_W-1:1]};
  assign shifted = msb ? {shift_q[DATA_W-2:0], din}
                       : ((lsb_sh & ~wmsk) | (din ? wmsk : 16'h0000));

  // frame sequencer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else if (!en) begin
      state_q <= ST_IDLE;
    end else if (load) begin
      state_q <= ST_RUN;
    end else if (frame_done) begin
      state_q <= ST_IDLE;
    end
  end

  // shift register and bit counter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 16'h0000;
      cnt_q   <= 5'h00;
    end else begin
      if (load) begin
        shift_q <= tb_q;
      end else if (sample_edge) begin
        shift_q <= shifted;
      end
      if (!en || load_start) begin
        cnt_q <= 5'h00;
      end else if (sample_edge) begin
        cnt_q <= frame_done ? 5'h00 : cnt_q + 5'h01;
      end
    end
  end

  // data out: slave presents first bit at once, master on the next tick
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_q <= 1'b1;
    end else if (!en) begin
      dout_q <= 1'b1;
    end else if (load_start || (load_cont && !master)) begin
      dout_q <= pick_bit(tb_q, width, msb);
    end else if (shift_edge && (state_q == ST_RUN || !master)) begin
      dout_q <= pick_bit(shift_q, width, msb);
    end
  end

  // master shift clock: low on tick, high at mid-bit while a frame runs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q      <= 1'b0;
      sclk_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= filt_q[PIN_CLK];
      if (!en || !master || baud_tick) begin
        sclk_q <= 1'b0;
      end else if (baud_mid && state_q == ST_RUN) begin
        sclk_q <= 1'b1;
      end
    end
  end

  // alternate outputs per role; unused ones held high
  assign alt_clk  = (en & master)  ? sclk_q : 1'b1;
  assign alt_mosi = (en & master)  ? dout_q : 1'b1;
  assign alt_miso = (en & ~master) ? dout_q : 1'b1;

  // pin drivers: latch AND alternate output, optional open drain on data
  assign pout_d = {port_q[PIN_MISO] & alt_miso,
                   port_q[PIN_MOSI] & alt_mosi,
                   port_q[PIN_CLK]  & alt_clk};
  assign poe_d  = {port_q[DIR_LO+PIN_MISO] & ~(od & pout_d[PIN_MISO]),
                   port_q[DIR_LO+PIN_MOSI] & ~(od & pout_d[PIN_MOSI]),
                   port_q[DIR_LO+PIN_CLK]};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pout_q <= 3'h0;
      poe_q  <= 3'h0;
    end else begin
      pout_q <= pout_d;
      poe_q  <= poe_d;
    end
  end

  // configuration registers; width and reload locked while enabled
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      baud_q <= BAUD_RST;
      port_q <= PORT_RST;
      mask_q <= STAT_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= en ? {reg_wdata[15:8], ctrl_q[7:4], reg_wdata[3:0]} : reg_wdata;
      end
      if (wr_baud && !en) begin
        baud_q <= reg_wdata;
      end
      if (wr_port) begin
        port_q <= reg_wdata;
      end
      if (wr_mask) begin
        mask_q <= reg_wdata[1:0];
      end
    end
  end

  // transmit buffer, receive buffer, sticky status and interrupt
  assign stat_set = {frame_done, load};
  assign stat_d   = (stat_q & ~(wr_stat ? reg_wdata[1:0] : 2'h0)) | stat_set;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tb_q      <= 16'h0000;
      tb_full_q <= 1'b0;
      rb_q      <= 16'h0000;
      stat_q    <= STAT_RST;
      irq_q     <= 1'b0;
    end else begin
      if (wr_tb) begin
        tb_q <= reg_wdata;
      end
      tb_full_q <= wr_tb | (tb_full_q & ~load);
      if (frame_done) begin
        rb_q <= shifted;
      end
      stat_q <= stat_d;
      irq_q  <= |(stat_d & mask_q);
    end
  end

  // read mux; reload register shows the running count while enabled
  always_comb begin
    unique case (reg_addr)
      OFS_CTRL: rd_mux = ctrl_q;
      OFS_TBUF: rd_mux = tb_q;
      OFS_RBUF: rd_mux = rb_q;
      OFS_BAUD: rd_mux = en ? baud_count : baud_q;
      OFS_STAT: rd_mux = {14'h0000, stat_q};
      OFS_MASK: rd_mux = {14'h0000, mask_q};
      OFS_PORT: rd_mux = port_q;
      default:  rd_mux = 16'h0000;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  // baud timer, running only while the channel is enabled
  sspb_baud u_baud (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .run      (en),
    .reload   (baud_q),
    .count    (baud_count),
    .tick     (baud_tick),
    .mid      (baud_mid)
  );

  assign reg_rdata    = rdata_q;
  assign irq          = irq_q;
  assign clk_pin_out  = pout_q[PIN_CLK];
  assign clk_pin_oe   = poe_q[PIN_CLK];
  assign mosi_pin_out = pout_q[PIN_MOSI];
  assign mosi_pin_oe  = poe_q[PIN_MOSI];
  assign miso_pin_out = pout_q[PIN_MISO];
  assign miso_pin_oe  = poe_q[PIN_MISO];

  property p_tx_flag;
    @(posedge core_clk) disable iff (!rst_n)
    load |=> stat_q[STAT_TX] && !tb_full_q || $past(wr_tb);
  endproperty
  a_tx_flag: assert property (p_tx_flag)
    else $error("transmit flag not set when buffer emptied");

  property p_no_gap;
    @(posedge core_clk) disable iff (!rst_n)
    en && frame_done && tb_full_q |=> state_q == ST_RUN && cnt_q == 5'h00
                                      && shift_q == $past(tb_q);
  endproperty
  a_no_gap: assert property (p_no_gap)
    else $error("refilled buffer did not continue the frame");

  property p_pin_and;
    @(posedge core_clk) disable iff (!rst_n)
    rst_n |=> mosi_pin_out == $past(port_q[PIN_MOSI] & alt_mosi)
             && clk_pin_out == $past(port_q[PIN_CLK] & alt_clk);
  endproperty
  a_pin_and: assert property (p_pin_and)
    else $error("pin output is not latch AND alternate output");

  property p_unused_high;
    @(posedge core_clk) disable iff (!rst_n)
    !(en && master) |-> alt_clk && alt_mosi;
  endproperty
  a_unused_high: assert property (p_unused_high)
    else $error("unused alternate output not held high");

  property p_width_lock;
    @(posedge core_clk) disable iff (!rst_n)
    en && wr_ctrl |=> ctrl_q[CTRL_WID_HI:CTRL_WID_LO] == $past(ctrl_q[CTRL_WID_HI:CTRL_WID_LO]);
  endproperty
  a_width_lock: assert property (p_width_lock)
    else $error("frame width changed while enabled");

  property p_baud_read;
    @(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFS_BAUD |=> reg_rdata == ($past(en) ? $past(baud_count)
                                                               : $past(baud_q));
  endproperty
  a_baud_read: assert property (p_baud_read)
    else $error("reload read returned the wrong value");

  property p_open_drain;
    @(posedge core_clk) disable iff (!rst_n)
    od && $stable(ctrl_q) |-> !(mosi_pin_oe && mosi_pin_out) && !(miso_pin_oe && miso_pin_out);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain pin actively drove high");

  property p_readback;
    @(posedge core_clk) disable iff (!rst_n)
    sample_edge && master && msb && !load |=> shift_q[0] == $past(filt_q[PIN_MISO]);
  endproperty
  a_readback: assert property (p_readback)
    else $error("master did not shift in its input line");

endmodule // sspb_top

// File: sim/sspb_far_station.sv
// far-side serial station on the shared half-duplex lines
module sspb_far_station (
  // shared lines
  input  wire logic        sclk_line,
  input  wire logic        data_line,
  output logic             sclk_drv,
  output logic             data_low,
  // bench control
  input  wire logic        master_mode,
  input  wire logic        go,
  input  wire logic [15:0] tx_word,
  input  wire logic [4:0]  nbits,
  output logic      [15:0] rx_word,
  output logic             busy
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;
  // idle: clock low, data released to the pull-up
  initial begin
    sclk_drv = 1'b0;
    data_low = 1'b0;
    rx_word = 16'h0;
    busy = 1'b0;
  end
  // frame start; as master the clock runs only inside the frame
  always @(posedge go) begin
    rx_word = 16'h0;
    cnt = 0;
    busy = 1'b1;
    data_low = ~tx_word[nbits-1];
    if (master_mode) begin
      repeat (nbits) begin
        #40 sclk_drv = 1'b1;
        #40 sclk_drv = 1'b0;
      end
      data_low = 1'b0;
      busy = 1'b0;
    end
  end
  // sample on rising edge, msb first
  always @(posedge sclk_line) begin
    if (busy) begin
      rx_word = {rx_word[14:0], data_line};
      cnt++;
    end
  end
  // next bit on falling edge, release after the last
  always @(negedge sclk_line) begin
    if (busy && cnt >= nbits) begin
      data_low = 1'b0;
      if (!master_mode) busy = 1'b0;
    end else if (busy) begin
      data_low = ~tx_word[nbits-1-cnt];
    end
  end
endmodule // sspb_far_station

// File: sim/sspb_top_tb.sv
// bench: registers, irq, pins, half-duplex frames and baud timing
module sspb_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sspb_pkg::*;
  localparam int RELOAD = 7;
  logic              core_clk;
  logic              rst_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic              irq;
  logic              clk_out, clk_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic              sclk_drv, data_low, far_master, far_go, far_busy, mon;
  logic [15:0]       far_tx, far_rx, v;
  logic [4:0]        far_bits;
  int                failures, comparisons, cyc, rises, last_rise;
  // wired lines: clock pulled low, data wired-and with pull-up
  wire sclk_line = clk_oe ? clk_out : sclk_drv;
  wire data_line = ~((mosi_oe & ~mosi_out) | (miso_oe & ~miso_out) | data_low);

  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  sspb_top DUT (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq),
    .clk_pin_in(sclk_line), .clk_pin_out(clk_out), .clk_pin_oe(clk_oe),
    .mosi_pin_in(data_line), .mosi_pin_out(mosi_out), .mosi_pin_oe(mosi_oe),
    .miso_pin_in(data_line), .miso_pin_out(miso_out), .miso_pin_oe(miso_oe)
  );

  sspb_far_station far (
    .sclk_line(sclk_line), .data_line(data_line), .sclk_drv(sclk_drv),
    .data_low(data_low), .master_mode(far_master), .go(far_go),
    .tx_word(far_tx), .nbits(far_bits), .rx_word(far_rx), .busy(far_busy)
  );

  // verdict and end of run
  task automatic close_out();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // read and compare
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] x;
    rd(a, x);
    chk(x, e);
  endtask

  // read and compare the low byte; bits above the frame width carry no meaning
  task automatic rcb(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    logic [DATA_W-1:0] x;
    rd(a, x);
    chk({8'h00, x[7:0]}, {8'h00, e});
  endtask

  // poll a status bit under a bound
  task automatic wait_stat(input int b);
    for (int i = 0; i < 300; i++) begin
      rd(OFS_STAT, v);
      if (v[b] === 1'b1) break;
    end
    chk({15'h0, v[b]}, 16'h1);
  endtask

  // wait for the far station to finish under a bound
  task automatic wait_far();
    @(posedge core_clk);
    for (int i = 0; i < 600 && far_busy; i++) @(posedge core_clk);
    chk({15'h0, far_busy}, 16'h0);
  endtask

  // cycle count and hang limit
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  // bit period and unused output on each rising shift clock
  always @(posedge clk_out) begin
    if (mon) begin
      if (rises > 0) chk(16'(cyc - last_rise), 16'(2 * (RELOAD + 1)));
      chk({15'h0, miso_out}, 16'h1);
      last_rise = cyc;
      rises++;
    end
  end

  // register indices and their values after reset
  logic [ADDR_W-1:0] ra [6] = '{OFS_CTRL, OFS_BAUD, OFS_PORT, OFS_STAT, OFS_MASK, 3'h7};
  logic [15:0]       ex [6] = '{CTRL_RST, BAUD_RST, PORT_RST, 16'h0, 16'h0, 16'h0};

  // main sequence
  initial begin
    rst_n = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    far_master = 1'b0;
    far_go = 1'b0;
    far_tx = 16'hffff;
    far_bits = 5'h08;
    mon = 1'b0;
    failures = 0;
    comparisons = 0;
    cyc = 0;
    rises = 0;
    last_rise = 0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    // reset values, unmapped index, idle pins
    wr(3'h7, 16'hbeef);
    for (int i = 0; i < 6; i++) rc(ra[i], ex[i]);
    chk({13'h0, miso_out, mosi_out, clk_out}, 16'h0007);
    chk({15'h0, irq}, 16'h0);
    // pin is latch and alternate output
    wr(OFS_PORT, 16'h0005);
    rc(OFS_PORT, 16'h0005);
    chk({13'h0, miso_out, mosi_out, clk_out}, 16'h0005);
    // master, open drain, msb first, 8 bits
    wr(OFS_BAUD, 16'(RELOAD));
    rc(OFS_BAUD, 16'(RELOAD));
    wr(OFS_PORT, 16'h0037);
    wr(OFS_MASK, 16'h0002);
    chk({13'h0, miso_oe, mosi_oe, clk_oe}, 16'h0003);
    wr(OFS_CTRL, 16'h007f);
    rd(OFS_BAUD, v);
    chk({15'h0, v <= 16'(RELOAD)}, 16'h1);
    chk({14'h0, miso_oe, mosi_oe}, 16'h0000);
    // far station sends while master sends ones
    far_tx <= 16'h003c;
    far_go <= 1'b1;
    wr(OFS_TBUF, 16'h00ff);
    wait_stat(STAT_RX);
    rcb(OFS_RBUF, 8'h3c);
    chk({15'h0, irq}, 16'h1);
    wr(OFS_STAT, 16'h0002);
    rc(OFS_STAT, 16'h0001);
    chk({15'h0, irq}, 16'h0);
    far_go <= 1'b0;
    far_tx <= 16'h00ff;
    // master reads back its own word
    @(posedge core_clk);
    far_go <= 1'b1;
    wr(OFS_TBUF, 16'h00a5);
    wait_stat(STAT_RX);
    rcb(OFS_RBUF, 8'ha5);
    chk(far_rx, 16'h00a5);
    far_go <= 1'b0;
    // width and reload refused while enabled
    wr(OFS_CTRL, 16'h003f);
    rc(OFS_CTRL, 16'h007f);
    wr(OFS_BAUD, 16'h0005);
    // chained frames without gap
    wr(OFS_STAT, 16'h0003);
    far_tx <= 16'hffff;
    far_bits <= 5'h10;
    mon = 1'b1;
    far_go <= 1'b1;
    wr(OFS_TBUF, 16'h0012);
    wait_stat(STAT_TX);
    wr(OFS_TBUF, 16'h0034);
    wait_far();
    mon = 1'b0;
    rcb(OFS_RBUF, 8'h34);
    chk(far_rx, 16'h1234);
    chk(16'(rises), 16'h0010);
    wr(OFS_CTRL, 16'h007e);
    rc(OFS_BAUD, 16'(RELOAD));
    // slave mode, far station clocks
    far_go <= 1'b0;
    wr(OFS_CTRL, 16'h007c);
    wr(OFS_STAT, 16'h0003);
    wr(OFS_PORT, 16'h0047);
    wr(OFS_CTRL, 16'h007d);
    wr(OFS_TBUF, 16'h005a);
    chk({13'h0, clk_oe, mosi_out, clk_out}, 16'h0003);
    far_master <= 1'b1;
    far_bits <= 5'h08;
    far_tx <= 16'h00ff;
    far_go <= 1'b1;
    wait_far();
    chk(far_rx, 16'h005a);
    wait_stat(STAT_RX);
    rcb(OFS_RBUF, 8'h5a);
    close_out();
  end
endmodule // sspb_top_tb
